// [core/rrsm_consts.svh]
// Timing counts and error thresholds for the redundancy role state machine.
// Assumes a 40 MHz core clock.
`ifndef RRSM_CONSTS_SVH
`define RRSM_CONSTS_SVH
`define RRSM_CLK_HZ 40000000
`define RRSM_WINDOW_S 1
`define RRSM_WINDOW_CYC (`RRSM_CLK_HZ * `RRSM_WINDOW_S)
`define RRSM_ERR_LIMIT 10
`define RRSM_CYCLE_CYC 400000
`endif

// [core/rrsm_pkg.sv]
// Types shared by the redundancy role state machine files.
// Assumes nothing beyond a SystemVerilog compiler.
package rrsm_pkg;
  typedef enum logic [2:0] {
    ST_INIT,
    ST_DISCOVERY,
    ST_AUTH,
    ST_STANDALONE,
    ST_ACTIVE,
    ST_PASSIVE,
    ST_FAULTED
  } rrsm_state_t;
endpackage

// [core/rrsm_err_if.sv]
// Bundle of error event strobes and window flags between the top and the rate checker.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface rrsm_err_if;
  logic [4:0] evt;
  logic [4:0] over;
  logic windowStart;
  modport mon
  (
    input evt,
    input windowStart,
    output over
  );
  modport top
  (
    output evt,
    output windowStart,
    input over
  );
endinterface // rrsm_err_if

// [core/rrsm_rate_chk.sv]
// Per-source error counters cleared each one-second window.
// Assumes windowStart pulses for one cycle at the start of each window.
`timescale 1ns/10ps
`include "rrsm_consts.svh"
module rrsm_rate_chk #(
  parameter int NUM = 5,
  parameter int CW = 5
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Event bundle
  rrsm_err_if.mon err
);
  localparam logic [CW-1:0] LIMIT = CW'(`RRSM_ERR_LIMIT);
  genvar g;
  generate
    for (g = 0; g < NUM; g++)
    begin : gen_cnt
      logic [CW-1:0] cnt_ff;
      logic over_ff;
      logic hit;
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          cnt_ff <= '0;
        else if (err.windowStart)
          cnt_ff <= '0;
        else if (err.evt[g] && cnt_ff != '1)
          cnt_ff <= cnt_ff + CW'(1);
      end
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          over_ff <= 1'b0;
        else if (hit)
          over_ff <= 1'b1;
        else if (err.windowStart)
          over_ff <= 1'b0;
      end
      // An excess in the closing cycle of a window is still flagged for that window.
      assign hit = err.evt[g] && cnt_ff >= LIMIT;
      assign err.over[g] = over_ff;
      property p_over_eleventh;
        @(posedge core_clk) disable iff (rst)
        (err.evt[g] && cnt_ff == LIMIT) |=> over_ff;
      endproperty
      a_over_eleventh: assert property (p_over_eleventh)
        else $error("rate flag missed the eleventh event");
      property p_clear_window;
        @(posedge core_clk) disable iff (rst)
        err.windowStart |=> (cnt_ff == '0 && over_ff == $past(hit));
      endproperty
      a_clear_window: assert property (p_clear_window)
        else $error("counter not cleared at window start");
    end
  endgenerate
endmodule // rrsm_rate_chk

// [core/rrsm_period.sv]
// Control-cycle tick and one-second window tick generator.
// Assumes a free-running core clock.
`timescale 1ns/10ps
`include "rrsm_consts.svh"
module rrsm_period #(
  parameter int CYCLE_CYC = `RRSM_CYCLE_CYC,
  parameter int WINDOW_CYC = `RRSM_WINDOW_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Ticks
  output logic cycleTick,
  output logic windowTick
);
  logic [31:0] cyc_ff;
  logic [31:0] win_ff;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cyc_ff <= '0;
    else if (cyc_ff == 32'(CYCLE_CYC - 1))
      cyc_ff <= '0;
    else
      cyc_ff <= cyc_ff + 32'h1;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      win_ff <= '0;
    else if (win_ff == 32'(WINDOW_CYC - 1))
      win_ff <= '0;
    else
      win_ff <= win_ff + 32'h1;
  end
  assign cycleTick = (cyc_ff == 32'(CYCLE_CYC - 1));
  assign windowTick = (win_ff == 32'(WINDOW_CYC - 1));
endmodule // rrsm_period

// [core/rrsm_top.sv]
// Redundancy role state machine for one controller of a redundant pair.
// Assumes partner status, link and fault inputs synchronous to core_clk.
// Operation
// - Reset enters init; init failure faults, else discovery.
// - Discovery: ack authenticates, no link standalone, else fault.
// - Equal qualification: second slot becomes active.
// - Standalone polls interlink, partner seen goes discovery.
// - Running states update diagnostics without changing state.
// - Active losing link goes standalone.
// - Passive losing link goes faulted.
// - Faulty active with healthy passive swaps roles.
// - Passive also initiates that swap.
// - Pending external switch request exchanges roles.
// - Running fault faults self; partner runs standalone.
// - Over ten ECC events per second faults.
// - Ethernet link loss or CRC excess faults.
// - Fabric frame or CRC excess faults.
// - Fabric drop excess swaps only if partner clean.
// - Power loss swaps only if partner redundant.
// - Interlink error excess faults, interlink off.
// - Watchdog expiry faults this controller.
// - Init failure disables interlink, no app; blink only with hwFault.
// - Boot auth failure: slot two active, slot one off.
`timescale 1ns/10ps
`include "rrsm_consts.svh"
module rrsm_top #(
  parameter int CYCLE_CYC = `RRSM_CYCLE_CYC,
  parameter int WINDOW_CYC = `RRSM_WINDOW_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Initialization results
  input wire logic initDone,
  input wire logic initFail,
  input wire logic hwFault,
  input wire logic slotTwo,
  // Interlink status
  input wire logic linkUp,
  input wire logic partnerAck,
  input wire logic discTimeout,
  input wire logic authDone,
  input wire logic authFail,
  input wire logic partnerRunning,
  input wire logic partnerWantsActive,
  // Partner diagnostics exchange
  input wire logic partnerFaulty,
  input wire logic partnerDropping,
  input wire logic partnerRedPower,
  input wire logic partnerSwapReq,
  // Local fault sources
  input wire logic eccEvt,
  input wire logic ethCrcEvt,
  input wire logic fabErrEvt,
  input wire logic fabDropEvt,
  input wire logic ilinkErrEvt,
  input wire logic ethLinkUp,
  input wire logic powerRedundant,
  input wire logic watchdogExpired,
  // Host role switch request
  input wire logic hostSwapReq,
  // Outputs
  output rrsm_pkg::rrsm_state_t state,
  output logic roleActive,
  output logic interlinkEnable,
  output logic appLoad,
  output logic blinkCode,
  output logic selfFaulty,
  output logic swapReq,
  output logic diagUpdate,
  output logic [15:0] diagCount
);
  rrsm_err_if err();
  rrsm_pkg::rrsm_state_t state_ff;
  rrsm_pkg::rrsm_state_t nxt_state;
  logic cycleTick;
  logic windowTick;
  logic ilinkOff_ff;
  logic appLoad_ff;
  logic blink_ff;
  logic swapPend_ff;
  logic [15:0] diag_ff;
  logic terminal;
  logic softFault;
  logic swapOk;
  logic running;

  rrsm_period #(
    .CYCLE_CYC(CYCLE_CYC),
    .WINDOW_CYC(WINDOW_CYC)
  ) u_period (
    .core_clk(core_clk),
    .rst(rst),
    .cycleTick(cycleTick),
    .windowTick(windowTick)
  );

  assign err.evt = {ilinkErrEvt, fabDropEvt, fabErrEvt, ethCrcEvt, eccEvt};
  assign err.windowStart = windowTick;

  rrsm_rate_chk #(
    .NUM(5),
    .CW(5)
  ) u_rate (
    .core_clk(core_clk),
    .rst(rst),
    .err(err.mon)
  );

  // Terminal faults send this controller to Faulted.
  assign terminal = err.over[0]
    | err.over[1] | !ethLinkUp
    | err.over[2]
    | err.over[4]
    | watchdogExpired;
  // Degrading faults only justify a swap when the partner is healthier.
  assign softFault = (err.over[3] && !partnerDropping)
    | (!powerRedundant && partnerRedPower);
  assign selfFaulty = terminal | softFault;
  assign running = (state_ff == rrsm_pkg::ST_STANDALONE) | (state_ff == rrsm_pkg::ST_ACTIVE)
    | (state_ff == rrsm_pkg::ST_PASSIVE);
  // Swap when healthy passive faces faulty active, or an external request pends.
  assign swapOk = (state_ff == rrsm_pkg::ST_ACTIVE && softFault && !partnerFaulty)
    | (state_ff == rrsm_pkg::ST_PASSIVE && partnerFaulty && !selfFaulty)
    | swapPend_ff | partnerSwapReq;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      rrsm_pkg::ST_INIT:
      begin
        if (initFail)
          nxt_state = rrsm_pkg::ST_FAULTED;
        else if (initDone)
          nxt_state = rrsm_pkg::ST_DISCOVERY;
      end
      rrsm_pkg::ST_DISCOVERY:
      begin
        if (!linkUp)
          nxt_state = rrsm_pkg::ST_STANDALONE;
        else if (partnerAck)
          nxt_state = rrsm_pkg::ST_AUTH;
        else if (discTimeout)
          nxt_state = rrsm_pkg::ST_FAULTED;
      end
      rrsm_pkg::ST_AUTH:
      begin
        if (authFail)
        begin
          // A running partner keeps control; at boot slot two wins.
          if (partnerRunning || !slotTwo)
            nxt_state = rrsm_pkg::ST_FAULTED;
          else
            nxt_state = rrsm_pkg::ST_STANDALONE;
        end
        else if (authDone)
        begin
          if (partnerWantsActive && !slotTwo)
            nxt_state = rrsm_pkg::ST_PASSIVE;
          else if (!partnerWantsActive || slotTwo)
            nxt_state = rrsm_pkg::ST_ACTIVE;
        end
      end
      rrsm_pkg::ST_STANDALONE:
      begin
        if (terminal)
          nxt_state = rrsm_pkg::ST_FAULTED;
        else if (cycleTick && linkUp && partnerAck)
          nxt_state = rrsm_pkg::ST_DISCOVERY;
      end
      rrsm_pkg::ST_ACTIVE:
      begin
        if (terminal)
          nxt_state = rrsm_pkg::ST_FAULTED;
        else if (cycleTick && !linkUp)
          nxt_state = rrsm_pkg::ST_STANDALONE;
        else if (cycleTick && swapOk)
          nxt_state = rrsm_pkg::ST_PASSIVE;
      end
      rrsm_pkg::ST_PASSIVE:
      begin
        if (terminal)
          nxt_state = rrsm_pkg::ST_FAULTED;
        else if (cycleTick && !linkUp)
          nxt_state = rrsm_pkg::ST_FAULTED;
        else if (cycleTick && swapOk)
          nxt_state = rrsm_pkg::ST_ACTIVE;
      end
      default:
      begin
        nxt_state = rrsm_pkg::ST_FAULTED;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_ff <= rrsm_pkg::ST_INIT;
    else
      state_ff <= nxt_state;
  end

  // In Active or Passive a host request is held until the next control cycle consumes it.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      swapPend_ff <= 1'b0;
    else if (hostSwapReq)
      swapPend_ff <= 1'b1;
    else if (cycleTick || !(state_ff == rrsm_pkg::ST_ACTIVE || state_ff == rrsm_pkg::ST_PASSIVE))
      swapPend_ff <= 1'b0;
  end

  // Diagnostic counter advances once per control cycle while running.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      diag_ff <= '0;
    else if (cycleTick && running)
      diag_ff <= diag_ff + 16'h1;
  end

  // Interlink is shut off on init failure, interlink errors or boot auth loss.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ilinkOff_ff <= 1'b0;
    else if (state_ff == rrsm_pkg::ST_INIT && initFail)
      ilinkOff_ff <= 1'b1;
    else if (running && err.over[4])
      ilinkOff_ff <= 1'b1;
    else if (state_ff == rrsm_pkg::ST_AUTH && authFail && nxt_state == rrsm_pkg::ST_FAULTED)
      ilinkOff_ff <= 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      appLoad_ff <= 1'b0;
    else if (nxt_state == rrsm_pkg::ST_FAULTED && state_ff == rrsm_pkg::ST_INIT)
      appLoad_ff <= 1'b0;
    else if (nxt_state == rrsm_pkg::ST_STANDALONE || nxt_state == rrsm_pkg::ST_ACTIVE
      || nxt_state == rrsm_pkg::ST_PASSIVE)
      appLoad_ff <= 1'b1;
    else if (nxt_state == rrsm_pkg::ST_FAULTED)
      appLoad_ff <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      blink_ff <= 1'b0;
    else if (state_ff == rrsm_pkg::ST_INIT && initFail && hwFault)
      blink_ff <= 1'b1;
  end

  assign state = state_ff;
  assign roleActive = (state_ff == rrsm_pkg::ST_ACTIVE) | (state_ff == rrsm_pkg::ST_STANDALONE);
  assign interlinkEnable = !ilinkOff_ff;
  assign appLoad = appLoad_ff;
  assign blinkCode = blink_ff;
  assign swapReq = cycleTick && swapOk && (state_ff == rrsm_pkg::ST_ACTIVE
    || state_ff == rrsm_pkg::ST_PASSIVE) && !terminal && linkUp;
  assign diagUpdate = cycleTick && running;
  assign diagCount = diag_ff;

  sequence s_init_fail;
    state_ff == rrsm_pkg::ST_INIT && initFail;
  endsequence
  sequence s_off_state;
    state_ff == rrsm_pkg::ST_FAULTED && ilinkOff_ff;
  endsequence

  property p_init_fail;
    @(posedge core_clk) disable iff (rst)
    s_init_fail |=> s_off_state ##0 !appLoad_ff;
  endproperty
  a_init_fail: assert property (p_init_fail)
    else $error("init failure did not fault with interlink off");

  property p_disc_nolink;
    @(posedge core_clk) disable iff (rst)
    (state_ff == rrsm_pkg::ST_DISCOVERY && !linkUp) |=> state_ff == rrsm_pkg::ST_STANDALONE;
  endproperty
  a_disc_nolink: assert property (p_disc_nolink)
    else $error("discovery without link did not go standalone");

  property p_active_loss;
    @(posedge core_clk) disable iff (rst)
    (state_ff == rrsm_pkg::ST_ACTIVE && cycleTick && !linkUp && !terminal)
      |=> state_ff == rrsm_pkg::ST_STANDALONE;
  endproperty
  a_active_loss: assert property (p_active_loss)
    else $error("active link loss did not go standalone");

  property p_passive_loss;
    @(posedge core_clk) disable iff (rst)
    (state_ff == rrsm_pkg::ST_PASSIVE && cycleTick && !linkUp) |=> state_ff == rrsm_pkg::ST_FAULTED;
  endproperty
  a_passive_loss: assert property (p_passive_loss)
    else $error("passive link loss did not fault");

  property p_terminal;
    @(posedge core_clk) disable iff (rst)
    (running && terminal) |=> state_ff == rrsm_pkg::ST_FAULTED;
  endproperty
  a_terminal: assert property (p_terminal)
    else $error("terminal fault did not fault");

  property p_watchdog;
    @(posedge core_clk) disable iff (rst)
    (state_ff == rrsm_pkg::ST_ACTIVE && watchdogExpired) |=> !roleActive;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog expiry left controller active");

  property p_diag_stay;
    @(posedge core_clk) disable iff (rst)
    (running && cycleTick && linkUp && !terminal && !swapOk
      && !(state_ff == rrsm_pkg::ST_STANDALONE && partnerAck))
      |=> $stable(state_ff) && diag_ff == $past(diag_ff) + 16'h1;
  endproperty
  a_diag_stay: assert property (p_diag_stay)
    else $error("diagnostic update changed state or missed count");

  property p_swap;
    @(posedge core_clk) disable iff (rst)
    (state_ff == rrsm_pkg::ST_PASSIVE && cycleTick && linkUp && !terminal && swapOk)
      |=> state_ff == rrsm_pkg::ST_ACTIVE;
  endproperty
  a_swap: assert property (p_swap)
    else $error("passive did not take over on swap");

  property p_boot_auth;
    @(posedge core_clk) disable iff (rst)
    (state_ff == rrsm_pkg::ST_AUTH && authFail && !partnerRunning && !slotTwo)
      |=> s_off_state;
  endproperty
  a_boot_auth: assert property (p_boot_auth)
    else $error("slot one did not go offline on boot auth failure");
endmodule // rrsm_top

// [dv/rrsm_partner_model.sv]
// Behavioural model of the partner controller across the interlink.
// Assumes it shares core_clk with the device and follows the device state combinationally.
`timescale 1ns/10ps
module rrsm_partner_model
(
  // Scenario controls
  input wire logic presentOn,
  input wire logic authOk,
  input wire logic authBad,
  input wire logic runningOn,
  input wire logic wantsOn,
  input wire logic faultyOn,
  input wire logic dropOn,
  input wire logic redPowerOn,
  input wire logic ackOff,
  // Device view
  input wire rrsm_pkg::rrsm_state_t devState,
  input wire logic devFaulty,
  // Toward the device
  output logic linkUp,
  output logic partnerAck,
  output logic authDone,
  output logic authFail,
  output logic partnerRunning,
  output logic partnerWantsActive,
  output logic partnerFaulty,
  output logic partnerDropping,
  output logic partnerRedPower,
  output logic partnerSwapReq
);
  assign linkUp = presentOn;
  assign partnerAck = presentOn && !ackOff;
  assign authDone = authOk && devState == rrsm_pkg::ST_AUTH;
  assign authFail = authBad && devState == rrsm_pkg::ST_AUTH;
  assign partnerRunning = runningOn;
  assign partnerWantsActive = wantsOn;
  assign partnerFaulty = faultyOn;
  assign partnerDropping = dropOn;
  assign partnerRedPower = redPowerOn;
  // A clean passive partner asks for the role when the active device is faulty.
  assign partnerSwapReq = devState == rrsm_pkg::ST_ACTIVE && devFaulty && !faultyOn &&
    !dropOn && redPowerOn;
endmodule // rrsm_partner_model

// [dv/testbench.sv]
// Self-checking testbench for the redundancy role state machine.
// Assumes the design and partner model files are compiled first.
`timescale 1ns/10ps
module testbench;
  localparam int CYC = 20;
  localparam int WIN = 200;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic initDone, initFail, hwFault, slotTwo, ethLinkUp, powerRedundant;
  logic watchdogExpired, hostSwapReq;
  logic [4:0] ev;
  logic presentOn, authOk, authBad, runningOn, wantsOn, faultyOn, dropOn, redPowerOn;
  logic linkUp, partnerAck, authDone, authFail, partnerRunning, partnerWantsActive;
  logic partnerFaulty, partnerDropping, partnerRedPower, partnerSwapReq;
  rrsm_pkg::rrsm_state_t state;
  logic roleActive, interlinkEnable, appLoad, blinkCode, selfFaulty;
  logic discTo, ackOff, swapReq, diagUpdate;
  logic [15:0] diagCount;
  int n_errors = 0;
  int total_checks = 0;
  int nDiag = 0;
  int nSwap = 0;

  always #12.5 core_clk = ~core_clk;

  // Counts the one-cycle status pulses so that scenarios can compare them.
  always @(posedge core_clk)
  begin
    if (diagUpdate === 1'h1)
      nDiag <= nDiag + 1;
    if (swapReq === 1'h1)
      nSwap <= nSwap + 1;
  end

  rrsm_top #(.CYCLE_CYC(CYC), .WINDOW_CYC(WIN)) rrsm_top_i
  (
    .core_clk(core_clk), .rst(rst), .initDone(initDone), .initFail(initFail),
    .hwFault(hwFault), .slotTwo(slotTwo), .linkUp(linkUp), .partnerAck(partnerAck),
    .discTimeout(discTo), .authDone(authDone), .authFail(authFail),
    .partnerRunning(partnerRunning), .partnerWantsActive(partnerWantsActive),
    .partnerFaulty(partnerFaulty), .partnerDropping(partnerDropping),
    .partnerRedPower(partnerRedPower), .partnerSwapReq(partnerSwapReq),
    .eccEvt(ev[0]), .ethCrcEvt(ev[1]), .fabErrEvt(ev[2]), .ilinkErrEvt(ev[3]),
    .fabDropEvt(ev[4]), .ethLinkUp(ethLinkUp), .powerRedundant(powerRedundant),
    .watchdogExpired(watchdogExpired), .hostSwapReq(hostSwapReq), .state(state),
    .roleActive(roleActive), .interlinkEnable(interlinkEnable), .appLoad(appLoad),
    .blinkCode(blinkCode), .selfFaulty(selfFaulty), .swapReq(swapReq), .diagUpdate(diagUpdate),
    .diagCount(diagCount)
  );

  rrsm_partner_model rrsm_partner_model_i
  (
    .presentOn(presentOn), .authOk(authOk), .authBad(authBad), .runningOn(runningOn),
    .wantsOn(wantsOn), .faultyOn(faultyOn), .dropOn(dropOn), .redPowerOn(redPowerOn),
    .ackOff(ackOff),
    .devState(state), .devFaulty(selfFaulty), .linkUp(linkUp), .partnerAck(partnerAck),
    .authDone(authDone), .authFail(authFail), .partnerRunning(partnerRunning),
    .partnerWantsActive(partnerWantsActive), .partnerFaulty(partnerFaulty),
    .partnerDropping(partnerDropping), .partnerRedPower(partnerRedPower),
    .partnerSwapReq(partnerSwapReq)
  );

  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %0b seen %0b", nm, e, g);
    end
  endtask

  // Polls every edge so that one-cycle states are not missed.
  task automatic wait_st(input rrsm_pkg::rrsm_state_t e, input int n);
    int i;
    for (i = 0; i < n && state !== e; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    total_checks++;
    if (state !== e)
    begin
      n_errors++;
      $display("[ERR] state expected %s seen %s", e.name(), state.name());
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'h1;
    {initDone, initFail, hwFault, slotTwo, hostSwapReq, watchdogExpired} <= 6'h00;
    {ethLinkUp, powerRedundant, redPowerOn} <= 3'h7;
    {presentOn, authOk, authBad, runningOn, wantsOn, faultyOn, dropOn} <= 7'h00;
    {ackOff, discTo} <= 2'h0;
    ev <= 5'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic run_up(input logic s2, input logic wa, input rrsm_pkg::rrsm_state_t e);
    do_reset();
    {slotTwo, wantsOn, presentOn, authOk, initDone} <= {s2, wa, 3'h7};
    wait_st(e, 10);
    @(posedge core_clk);
  endtask

  task automatic burst(input int i, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      ev[i] <= 1'h1;
      @(posedge core_clk);
      ev[i] <= 1'h0;
    end
  endtask

  task automatic t_init();
    int h;
    for (h = 1; h >= 0; h--)
    begin
      do_reset();
      {initFail, hwFault} <= {1'h1, h == 1};
      wait_st(rrsm_pkg::ST_FAULTED, 5);
      @(posedge core_clk);
      #1;
      chk1("interlinkEnable", 1'h0, interlinkEnable);
      chk1("appLoad", 1'h0, appLoad);
      chk1("blinkCode", h == 1, blinkCode);
    end
    $display("test init done");
  endtask

  task automatic t_alone();
    do_reset();
    initDone <= 1'h1;
    wait_st(rrsm_pkg::ST_DISCOVERY, 5);
    wait_st(rrsm_pkg::ST_STANDALONE, 5);
    @(posedge core_clk);
    presentOn <= 1'h1;
    #1;
    chk1("appLoad", 1'h1, appLoad);
    chk1("roleActive", 1'h1, roleActive);
    wait_st(rrsm_pkg::ST_DISCOVERY, CYC + 5);
    wait_st(rrsm_pkg::ST_AUTH, 5);
    $display("test standalone done");
  endtask

  task automatic t_disc();
    do_reset();
    {presentOn, ackOff, initDone} <= 3'h7;
    wait_st(rrsm_pkg::ST_DISCOVERY, 5);
    repeat (3) @(posedge core_clk);
    chk1("discWait", 1'h1, state === rrsm_pkg::ST_DISCOVERY);
    discTo <= 1'h1;
    wait_st(rrsm_pkg::ST_FAULTED, 3);
    $display("test discovery timeout done");
  endtask

  task automatic t_roles();
    logic [15:0] c0;
    int d0;
    int s0;
    run_up(1'h1, 1'h1, rrsm_pkg::ST_ACTIVE);
    c0 = diagCount;
    d0 = nDiag;
    repeat (2 * CYC + 2) @(posedge core_clk);
    #1;
    chk1("diagCount", 1'h1, diagCount === c0 + 16'h2);
    chk1("diagUpdate", 1'h1, nDiag === d0 + 2);
    chk1("stayActive", 1'h1, state === rrsm_pkg::ST_ACTIVE);
    s0 = nSwap;
    @(posedge core_clk);
    hostSwapReq <= 1'h1;
    @(posedge core_clk);
    hostSwapReq <= 1'h0;
    wait_st(rrsm_pkg::ST_PASSIVE, CYC + 5);
    chk1("swapReq", 1'h1, nSwap === s0 + 1);
    @(posedge core_clk);
    faultyOn <= 1'h1;
    wait_st(rrsm_pkg::ST_ACTIVE, CYC + 5);
    @(posedge core_clk);
    {faultyOn, presentOn} <= 2'h0;
    wait_st(rrsm_pkg::ST_STANDALONE, CYC + 5);
    run_up(1'h0, 1'h1, rrsm_pkg::ST_PASSIVE);
    presentOn <= 1'h0;
    wait_st(rrsm_pkg::ST_FAULTED, CYC + 5);
    $display("test roles done");
  endtask

  task automatic t_soft();
    run_up(1'h1, 1'h0, rrsm_pkg::ST_ACTIVE);
    dropOn <= 1'h1;
    burst(4, 11);
    repeat (CYC + 5) @(posedge core_clk);
    chk1("dropHold", 1'h1, state === rrsm_pkg::ST_ACTIVE);
    dropOn <= 1'h0;
    wait_st(rrsm_pkg::ST_PASSIVE, CYC + 5);
    run_up(1'h1, 1'h0, rrsm_pkg::ST_ACTIVE);
    {powerRedundant, redPowerOn} <= 2'h0;
    repeat (CYC + 5) @(posedge core_clk);
    chk1("powerHold", 1'h1, state === rrsm_pkg::ST_ACTIVE);
    redPowerOn <= 1'h1;
    wait_st(rrsm_pkg::ST_PASSIVE, CYC + 5);
    $display("test soft faults done");
  endtask

  task automatic t_hard();
    int i;
    for (i = 0; i < 4; i++)
    begin
      run_up(1'h1, 1'h0, rrsm_pkg::ST_ACTIVE);
      burst(i, 10);
      repeat (5) @(posedge core_clk);
      chk1("tenAllowed", 1'h1, state === rrsm_pkg::ST_ACTIVE);
      burst(i, 1);
      wait_st(rrsm_pkg::ST_FAULTED, 4);
    end
    @(posedge core_clk);
    #1;
    chk1("interlinkEnable", 1'h0, interlinkEnable);
    run_up(1'h1, 1'h0, rrsm_pkg::ST_ACTIVE);
    ethLinkUp <= 1'h0;
    wait_st(rrsm_pkg::ST_FAULTED, 4);
    run_up(1'h1, 1'h0, rrsm_pkg::ST_ACTIVE);
    watchdogExpired <= 1'h1;
    wait_st(rrsm_pkg::ST_FAULTED, 4);
    $display("test hard faults done");
  endtask

  task automatic t_auth();
    int i;
    for (i = 0; i < 3; i++)
    begin
      do_reset();
      {slotTwo, runningOn, presentOn, authBad, initDone} <= {i != 0, i == 2, 3'h7};
      wait_st(i == 1 ? rrsm_pkg::ST_STANDALONE : rrsm_pkg::ST_FAULTED, 10);
      @(posedge core_clk);
      #1;
      if (i == 0)
        chk1("interlinkEnable", 1'h0, interlinkEnable);
      if (i == 1)
        chk1("roleActive", 1'h1, roleActive);
    end
    $display("test auth done");
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    t_init();
    t_alone();
    t_disc();
    t_roles();
    t_soft();
    t_hard();
    t_auth();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
endmodule // testbench
